//--- rtl/dregc_chan.sv
/*
  One regulator's control decode: turns its two control bytes and the
  synchronised enable pin into registered run, discharge and mode lines.
  Assumes both bytes and the pin level are already on this clock.
*/
module dregc_chan (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic [7:0]              control,
  input  wire logic [7:0]              limit_slew,
  input  wire logic                    en_pin,
  output dregc_pkg::dregc_ch_out_t     settings
);

  dregc_pkg::dregc_ch_out_t out_reg;
  dregc_pkg::dregc_ch_out_t out_next;
  logic                     run_now;

  // ----------------------------------------------------------------
  // decode, recomputed every cycle so limit changes land while running
  // ----------------------------------------------------------------
  always_comb begin
    run_now = control[dregc_pkg::BIT_ON] &
              (~control[dregc_pkg::BIT_PIN_GATE] | en_pin);
    out_next.run       = run_now;
    out_next.discharge = control[dregc_pkg::BIT_DISCHARGE] & ~run_now;
    out_next.force_pwm = control[dregc_pkg::BIT_FORCE_PWM];
    out_next.current_limit_code =
      limit_slew[dregc_pkg::LIM_LSB +: dregc_pkg::CODE_W];
    out_next.ramp_code = limit_slew[dregc_pkg::RAMP_LSB +: dregc_pkg::CODE_W];
  end

  // safe state under reset: off, discharge path connected
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_reg <= '{run: 1'b0, discharge: 1'b1, force_pwm: 1'b0,
                   current_limit_code: '0, ramp_code: '0};
    end else begin
      out_reg <= out_next;
    end
  end

  assign settings = out_reg;

endmodule

//--- rtl/dregc_pkg.sv
/*
  Shared constants and carrier types for the dual regulator control bank.
  Assumes a byte-wide register port driven by the serial interface logic
  on the same clock, and an nvm loader that pulses once after reading.
*/
// Contract
// - mode bit 3 of control byte: 0 automatic pfm/pwm, 1 forced pwm.
// - bit 2 connects discharge path while regulator is off; resets to one.
// - bit 1 set: regulator runs only when enable bit and enable pin both high.
// - bit 0 turns regulator off when 0, on when 1, subject to pin gating.
// - current-limit code in bits 5:3, 1.5 A to 4.0 A, codes 6-7 reserved.
// - new current-limit code applies at once, even while regulator runs.
// - ramp code in bits 2:0, same rate both directions, codes 0-1 reserved.
// - identity byte: read-only part code in 7:6, read-only reserved 5:0.
// - offset one: read-only eight-bit nvm content version code.
// - nvm-dependent bits are loaded from nvm before normal operation.
// - all control registers read and written over the serial interface.
package dregc_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_DEVICE_IDENTITY  = 8'h00;
  localparam logic [7:0] OFS_OTP_VERSION      = 8'h01;
  localparam logic [7:0] OFS_REG0_CONTROL     = 8'h02;
  localparam logic [7:0] OFS_REG0_LIMIT_SLEW  = 8'h03;
  localparam logic [7:0] OFS_REG1_CONTROL     = 8'h04;
  localparam logic [7:0] OFS_REG1_LIMIT_SLEW  = 8'h05;
  localparam logic [7:0] OFS_TOP_MASK_A       = 8'h20;
  localparam logic [7:0] OFS_TOP_MASK_B       = 8'h21;
  localparam logic [7:0] OFS_REG_MASK         = 8'h22;
  localparam logic [7:0] OFS_LOAD_SELECT      = 8'h24;
  localparam logic [7:0] OFS_LOAD_HIGH        = 8'h25;
  localparam logic [7:0] OFS_LOAD_LOW         = 8'h26;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_ON        = 0;
  localparam int BIT_PIN_GATE  = 1;
  localparam int BIT_DISCHARGE = 2;
  localparam int BIT_FORCE_PWM = 3;
  localparam int LIM_LSB       = 3;
  localparam int RAMP_LSB      = 0;
  localparam int CODE_W        = 3;

  // writable bits of the mask and select registers, others read zero
  localparam logic [7:0] TOP_MASK_A_BITS = 8'h95;
  localparam logic [7:0] TOP_MASK_B_BITS = 8'h01;
  localparam logic [7:0] REG_MASK_BITS   = 8'hDD;
  localparam logic [7:0] LOAD_SEL_BITS   = 8'h01;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CONTROL    = 8'h04;
  localparam logic [7:0] RST_LIMIT_SLEW = 8'h00;
  localparam logic [7:0] RST_ZERO       = 8'h00;
  localparam logic [5:0] IDENT_LOW_BITS = 6'h02;

  // nvm image for one regulator: nvm-dependent control fields
  typedef struct packed {
    logic              force_pwm;
    logic              pin_gating;
    logic              regulator_on;
    logic [CODE_W-1:0] current_limit_code;
    logic [CODE_W-1:0] ramp_code;
  } dregc_nvm_ch_t;

  // whole nvm image delivered by the loader
  typedef struct packed {
    logic [1:0]       part_code;
    logic [7:0]       nvm_version_code;
    dregc_nvm_ch_t [1:0] ch;
  } dregc_nvm_t;

  // settings handed to one regulator's analog control
  typedef struct packed {
    logic              run;
    logic              discharge;
    logic              force_pwm;
    logic [CODE_W-1:0] current_limit_code;
    logic [CODE_W-1:0] ramp_code;
  } dregc_ch_out_t;

endpackage

//--- rtl/dregc_regs.sv
/*
  Control and status register bank of the dual step-down regulator.
  Assumes the serial interface logic presents byte accesses on this clock
  (one-cycle read and write strobes), an nvm loader pulse on this clock,
  load-current readings on this clock, and an asynchronous enable pin.
  Readings are nine to sixteen bits wide; the byte pair shows the low nine,
  so a wider reading loses its top bits when the host reads it.
*/
module dregc_regs #(
  parameter int ILOAD_W = 9
) (
  input  wire logic                          CLK_SYS,
  input  wire logic                          RSTN,
  input  wire logic [7:0]                    REG_ADDR,
  input  wire logic                          REG_WR,
  input  wire logic [7:0]                    REG_WDATA,
  input  wire logic                          REG_RD,
  output logic [7:0]                         REG_RDATA,
  input  wire logic                          NVM_LOAD,
  input  wire dregc_pkg::dregc_nvm_t         NVM_IMAGE,
  input  wire logic                          EN_PIN,
  input  wire logic [ILOAD_W-1:0]            LOAD_CURRENT_CH0,
  input  wire logic [ILOAD_W-1:0]            LOAD_CURRENT_CH1,
  output dregc_pkg::dregc_ch_out_t [1:0]     CH_SETTINGS,
  output logic [7:0]                         TOP_MASK_A,
  output logic [7:0]                         TOP_MASK_B,
  output logic [7:0]                         REG_MASK,
  output logic                               LOAD_SELECT
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  // the byte pair needs nine bits; beyond sixteen the select mux only grows
  // and nothing reads the extra bits
  if (ILOAD_W < 9 || ILOAD_W > 16) begin : g_bad_width
    $error("load current width must be 9 to 16 bits");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [1:0]       part_code_reg,     part_code_next;
  logic [7:0]       nvm_version_reg,   nvm_version_next;
  // reserved control bits are stored as written; the host is trusted to write zeros
  logic [7:0]       control_reg [2],   control_next [2];
  logic [7:0]       limit_slew_reg [2], limit_slew_next [2];
  logic [7:0]       mask_a_reg,        mask_a_next;
  logic [7:0]       mask_b_reg,        mask_b_next;
  logic [7:0]       reg_mask_reg,      reg_mask_next;
  logic             load_sel_reg,      load_sel_next;
  logic [7:0]       rdata_reg,         rdata_next;
  logic             en_meta_reg,       en_sync_reg;
  logic [ILOAD_W-1:0] load_pick;

  // bit-wise merge of nvm fields into a control byte, used per channel
  function automatic logic [7:0] nvm_control(input logic [7:0] cur,
                                             input dregc_pkg::dregc_nvm_ch_t n);
    logic [7:0] v;
    v = cur;
    // discharge and reserved bits are not nvm-dependent and keep their value
    v[dregc_pkg::BIT_FORCE_PWM] = n.force_pwm;
    v[dregc_pkg::BIT_PIN_GATE]  = n.pin_gating;
    v[dregc_pkg::BIT_ON]        = n.regulator_on;
    return v;
  endfunction

  function automatic logic [7:0] nvm_limit(input logic [7:0] cur,
                                           input dregc_pkg::dregc_nvm_ch_t n);
    logic [7:0] v;
    v = cur;
    // reserved bits 7:6 are left as they stand
    v[dregc_pkg::LIM_LSB +: dregc_pkg::CODE_W]  = n.current_limit_code;
    v[dregc_pkg::RAMP_LSB +: dregc_pkg::CODE_W] = n.ramp_code;
    return v;
  endfunction

  // ----------------------------------------------------------------
  // enable pin synchroniser: second stage is the only reader of the first
  // ----------------------------------------------------------------
  // both stages clear in reset so a pin-gated regulator starts off
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      en_meta_reg <= 1'b0;
      en_sync_reg <= 1'b0;
    end else begin
      en_meta_reg <= EN_PIN;
      en_sync_reg <= en_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // register next values: nvm load first, then a host write on top
  // ----------------------------------------------------------------
  always_comb begin
    part_code_next   = part_code_reg;
    nvm_version_next = nvm_version_reg;
    control_next     = control_reg;
    limit_slew_next  = limit_slew_reg;
    mask_a_next      = mask_a_reg;
    mask_b_next      = mask_b_reg;
    reg_mask_next    = reg_mask_reg;
    load_sel_next    = load_sel_reg;
    // nvm-dependent fields only; reserved and discharge bits keep their value
    if (NVM_LOAD) begin
      part_code_next   = NVM_IMAGE.part_code;
      nvm_version_next = NVM_IMAGE.nvm_version_code;
      for (int c = 0; c < 2; c++) begin
        control_next[c]    = nvm_control(control_reg[c], NVM_IMAGE.ch[c]);
        limit_slew_next[c] = nvm_limit(limit_slew_reg[c], NVM_IMAGE.ch[c]);
      end
    end
    // a write in the load cycle is applied last, so the host value wins
    // identity and version are not writable; unmapped writes are dropped
    if (REG_WR) begin
      unique case (REG_ADDR)
        dregc_pkg::OFS_REG0_CONTROL:    control_next[0]    = REG_WDATA;
        dregc_pkg::OFS_REG0_LIMIT_SLEW: limit_slew_next[0] = REG_WDATA;
        dregc_pkg::OFS_REG1_CONTROL:    control_next[1]    = REG_WDATA;
        dregc_pkg::OFS_REG1_LIMIT_SLEW: limit_slew_next[1] = REG_WDATA;
        // masks keep only their field bits, the rest read zero
        dregc_pkg::OFS_TOP_MASK_A:      mask_a_next   = REG_WDATA & dregc_pkg::TOP_MASK_A_BITS;
        dregc_pkg::OFS_TOP_MASK_B:      mask_b_next   = REG_WDATA & dregc_pkg::TOP_MASK_B_BITS;
        dregc_pkg::OFS_REG_MASK:        reg_mask_next = REG_WDATA & dregc_pkg::REG_MASK_BITS;
        dregc_pkg::OFS_LOAD_SELECT:     load_sel_next = |(REG_WDATA & dregc_pkg::LOAD_SEL_BITS);
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read data, registered one cycle after the strobe, held otherwise
  // ----------------------------------------------------------------
  // readings are live, so the host reads the high byte and then the low byte
  always_comb begin
    load_pick  = load_sel_reg ? LOAD_CURRENT_CH1 : LOAD_CURRENT_CH0;
    rdata_next = rdata_reg;
    if (REG_RD) begin
      unique case (REG_ADDR)
        dregc_pkg::OFS_DEVICE_IDENTITY:
          rdata_next = {part_code_reg, dregc_pkg::IDENT_LOW_BITS};
        dregc_pkg::OFS_OTP_VERSION:     rdata_next = nvm_version_reg;
        dregc_pkg::OFS_REG0_CONTROL:    rdata_next = control_reg[0];
        dregc_pkg::OFS_REG0_LIMIT_SLEW: rdata_next = limit_slew_reg[0];
        dregc_pkg::OFS_REG1_CONTROL:    rdata_next = control_reg[1];
        dregc_pkg::OFS_REG1_LIMIT_SLEW: rdata_next = limit_slew_reg[1];
        dregc_pkg::OFS_TOP_MASK_A:      rdata_next = mask_a_reg;
        dregc_pkg::OFS_TOP_MASK_B:      rdata_next = mask_b_reg;
        dregc_pkg::OFS_REG_MASK:        rdata_next = reg_mask_reg;
        dregc_pkg::OFS_LOAD_SELECT:     rdata_next = {7'h00, load_sel_reg};
        dregc_pkg::OFS_LOAD_HIGH:       rdata_next = {7'h00, load_pick[8]};
        dregc_pkg::OFS_LOAD_LOW:        rdata_next = load_pick[7:0];
        // a probe of an unmapped offset sees zero, never stale data
        default:                        rdata_next = dregc_pkg::RST_ZERO;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers; nvm-dependent bits start at zero until the loader runs
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      part_code_reg   <= 2'h0;
      nvm_version_reg <= dregc_pkg::RST_ZERO;
      // control bytes come up with only the discharge bit set
      for (int c = 0; c < 2; c++) begin
        control_reg[c]    <= dregc_pkg::RST_CONTROL;
        limit_slew_reg[c] <= dregc_pkg::RST_LIMIT_SLEW;
      end
      mask_a_reg   <= dregc_pkg::RST_ZERO;
      mask_b_reg   <= dregc_pkg::RST_ZERO;
      reg_mask_reg <= dregc_pkg::RST_ZERO;
      load_sel_reg <= 1'b0;
    end else begin
      part_code_reg   <= part_code_next;
      nvm_version_reg <= nvm_version_next;
      control_reg     <= control_next;
      limit_slew_reg  <= limit_slew_next;
      mask_a_reg      <= mask_a_next;
      mask_b_reg      <= mask_b_next;
      reg_mask_reg    <= reg_mask_next;
      load_sel_reg    <= load_sel_next;
    end
  end

  // ----------------------------------------------------------------
  // read data register, apart from the bank so its group has one pair
  // ----------------------------------------------------------------
  // the read port resets to zero so a host never sees leftover data after reset
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      rdata_reg <= dregc_pkg::RST_ZERO;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // per-regulator decode
  // ----------------------------------------------------------------
  // the channel register adds one edge between a control byte and its output
  for (genvar c = 0; c < 2; c++) begin : g_ch
    dregc_chan u_chan (
      .clk        (CLK_SYS),
      .rst_n      (RSTN),
      .control    (control_reg[c]),
      .limit_slew (limit_slew_reg[c]),
      .en_pin     (en_sync_reg),
      .settings   (CH_SETTINGS[c])
    );
  end

  // ----------------------------------------------------------------
  // outputs, each straight from a register
  // ----------------------------------------------------------------
  // masks and select leave as stored; the interrupt logic reads them there
  assign REG_RDATA   = rdata_reg;
  assign TOP_MASK_A  = mask_a_reg;
  assign TOP_MASK_B  = mask_b_reg;
  assign REG_MASK    = reg_mask_reg;
  assign LOAD_SELECT = load_sel_reg;

endmodule

//--- verification/dregc_host.sv
/*
  Host model issuing byte accesses to the register bank.
  Assumes tasks are called 2 ns after a rising edge of clk.
*/
module dregc_host (
  input  wire logic       clk,
  output logic [7:0]      addr,
  output logic            wr,
  output logic [7:0]      wdata,
  output logic            rd,
  input  wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial begin
    addr = 8'h00;
    wr = 1'b0;
    wdata = 8'h00;
    rd = 1'b0;
  end
  // each access waits an edge first so two strobes never merge
  task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #2;
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk);
    #2;
    wr = 1'b0;
    wdata = ~d; // released data must not look valid
  endtask
  // read byte lands on the edge that takes the strobe
  task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #2;
    addr = a;
    rd = 1'b1;
    @(posedge clk);
    #2;
    rd = 1'b0;
    d = rdata;
  endtask
endmodule

//--- verification/dregc_regs_properties.sv
/*
  Port checker for the regulator control bank.
  Assumes one clock domain and the register strobe timing of the bank.
*/
module dregc_chk #(
  parameter int ILOAD_W = 9
) (
  input wire logic                      CLK_SYS,
  input wire logic                      RSTN,
  input wire logic [7:0]                REG_ADDR,
  input wire logic                      REG_WR,
  input wire logic [7:0]                REG_WDATA,
  input wire logic                      REG_RD,
  input wire logic [7:0]                REG_RDATA,
  input wire logic                      NVM_LOAD,
  input wire dregc_pkg::dregc_nvm_t     NVM_IMAGE,
  input wire dregc_pkg::dregc_ch_out_t [1:0] CH_SETTINGS,
  input wire logic [7:0]                TOP_MASK_A,
  input wire logic [7:0]                REG_MASK
);
  // ------------------------------------------------------------
  // port relations
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  chk_rdata_hold: assert property (!REG_RD |=> $stable(REG_RDATA))
    else $error("read data moved without a read");
  chk_write_back: assert property (
    (REG_WR && REG_ADDR inside {[8'h02:8'h05]} && !NVM_LOAD) ##1 (!REG_WR && !NVM_LOAD)
    ##1 (REG_RD && !REG_WR && REG_ADDR == $past(REG_ADDR, 2))
    |=> REG_RDATA == $past(REG_WDATA, 3)) else $error("written byte not read back");
  chk_ident_low: assert property (REG_RD && REG_ADDR == 8'h00 |=> REG_RDATA[5:0] == 6'h02)
    else $error("identity low bits wrong");
  chk_unmapped_zero: assert property (REG_RD && REG_ADDR > 8'h26 |=> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  chk_run_follow: assert property (
    (REG_WR && REG_ADDR == 8'h02 && !REG_WDATA[1]) ##1 !(REG_WR || NVM_LOAD)
    |=> CH_SETTINGS[0].run == $past(REG_WDATA[0], 2)
    && CH_SETTINGS[0].discharge == ($past(REG_WDATA[2], 2) && !$past(REG_WDATA[0], 2))
    && CH_SETTINGS[0].force_pwm == $past(REG_WDATA[3], 2)) else $error("run or mode wrong");
  chk_code_follow: assert property (
    (REG_WR && REG_ADDR == 8'h05) ##1 !(REG_WR || NVM_LOAD)
    |=> CH_SETTINGS[1].current_limit_code == $past(REG_WDATA[5:3], 2)
    && CH_SETTINGS[1].ramp_code == $past(REG_WDATA[2:0], 2)) else $error("codes not applied");
  chk_discharge_off: assert property (!(CH_SETTINGS[0].run && CH_SETTINGS[0].discharge)
    && !(CH_SETTINGS[1].run && CH_SETTINGS[1].discharge)) else $error("discharge while on");
  chk_reset_state: assert property ($rose(RSTN) |-> CH_SETTINGS[0].discharge
    && !CH_SETTINGS[0].run && REG_RDATA == 8'h00) else $error("reset state wrong");
  chk_mask_bits: assert property (
    (TOP_MASK_A & 8'h6A) == 8'h00 && (REG_MASK & 8'h22) == 8'h00)
    else $error("reserved mask bit set");
  chk_nvm_apply: assert property ((NVM_LOAD && !REG_WR) ##1 !(REG_WR || NVM_LOAD)
    |=> CH_SETTINGS[1].ramp_code == $past(NVM_IMAGE.ch[1].ramp_code, 2))
    else $error("nvm ramp code not applied");
endmodule

bind dregc_regs dregc_chk #(.ILOAD_W(ILOAD_W)) u_chk (.CLK_SYS, .RSTN, .REG_ADDR, .REG_WR,
  .REG_WDATA, .REG_RD, .REG_RDATA, .NVM_LOAD, .NVM_IMAGE, .CH_SETTINGS, .TOP_MASK_A, .REG_MASK);

//--- verification/test_dual_regulator_control_regs.sv
/*
  Self-checking bench for the regulator control bank.
  Assumes the host model drives the register port and the bench the rest.
*/
module test_dual_regulator_control_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, mask_a, mask_b, reg_mask, c, l, d;
  logic reg_wr, reg_rd, load_select, ch, nvm_load = 1'b0, en_pin = 1'b0;
  logic [8:0] cur0 = 9'h000, cur1 = 9'h000;
  logic [31:0] seed = 32'h0000_0006, r;
  dregc_pkg::dregc_nvm_t nvm_image = '0;
  dregc_pkg::dregc_ch_out_t [1:0] ch_settings;
  logic [7:0] ofs [4] = '{8'h20, 8'h21, 8'h22, 8'h24};
  logic [7:0] fld [4] = '{8'h95, 8'h01, 8'hDD, 8'h01};
  int mismatches = 0, comparisons = 0, cycles = 0;

  always #12.5 clk_sys = ~clk_sys;

  dregc_host host (.clk(clk_sys), .addr(reg_addr), .wr(reg_wr), .wdata(reg_wdata),
    .rd(reg_rd), .rdata(reg_rdata));
  dregc_regs #(.ILOAD_W(9)) dut (.CLK_SYS(clk_sys), .RSTN(rstn), .REG_ADDR(reg_addr),
    .REG_WR(reg_wr), .REG_WDATA(reg_wdata), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .NVM_LOAD(nvm_load), .NVM_IMAGE(nvm_image), .EN_PIN(en_pin), .LOAD_CURRENT_CH0(cur0),
    .LOAD_CURRENT_CH1(cur1), .CH_SETTINGS(ch_settings), .TOP_MASK_A(mask_a),
    .TOP_MASK_B(mask_b), .REG_MASK(reg_mask), .LOAD_SELECT(load_select));

  // xorshift source, fixed start so runs repeat
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // expected regulator outputs from its two control bytes and the pin
  function automatic dregc_pkg::dregc_ch_out_t exp_ch(logic [7:0] c, logic [7:0] l, logic p);
    dregc_pkg::dregc_ch_out_t e;
    e.run = c[0] & (~c[1] | p);
    e.discharge = c[2] & ~e.run;
    e.force_pwm = c[3];
    e.current_limit_code = l[5:3];
    e.ramp_code = l[2:0];
    return e;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic check_rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    host.rd_byte(a, v);
    check({8'h00, v}, {8'h00, e});
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // hang guard, far above the length of the sequence
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    #2 rstn = 1'b1;
    check({7'h00, ch_settings[0]}, {7'h00, exp_ch(8'h04, 8'h00, 1'b0)});
    check({7'h00, ch_settings[1]}, {7'h00, exp_ch(8'h04, 8'h00, 1'b0)});
    for (int a = 2; a < 6; a++) check_rd(8'(a), a[0] ? 8'h00 : 8'h04);
    $display("reset values done");
    r = rnd();
    nvm_image = r[27:0];
    nvm_load = 1'b1;
    @(posedge clk_sys);
    #2 nvm_load = 1'b0;
    check_rd(8'h00, {nvm_image.part_code, 6'h02});
    check_rd(8'h01, nvm_image.nvm_version_code);
    check_rd(8'h02, {4'h0, nvm_image.ch[0].force_pwm, 1'b1, nvm_image.ch[0].pin_gating,
      nvm_image.ch[0].regulator_on});
    check_rd(8'h05, {2'b00, nvm_image.ch[1].current_limit_code,
      nvm_image.ch[1].ramp_code});
    host.wr_byte(8'h00, 8'hFF);
    host.wr_byte(8'h01, 8'hFF);
    check_rd(8'h00, {nvm_image.part_code, 6'h02});
    check_rd(8'h01, nvm_image.nvm_version_code);
    $display("nvm load done");
    // random control bytes, every legal limit and ramp code in turn
    for (int i = 0; i < 24; i++) begin
      r = rnd();
      c = {4'h0, r[3:0]};
      l = {2'b00, 3'(i % 6), 3'(2 + i % 6)};
      ch = r[4];
      en_pin = r[5];
      // channel 0 sits at 0x02 and 0x03, channel 1 at 0x04 and 0x05
      host.wr_byte({5'h00, ch, ~ch, 1'b0}, c);
      check_rd({5'h00, ch, ~ch, 1'b0}, c);
      host.wr_byte({5'h00, ch, ~ch, 1'b1}, l);
      check_rd({5'h00, ch, ~ch, 1'b1}, l);
      repeat (4) @(posedge clk_sys);
      #2 check({7'h00, ch_settings[ch]},
        {7'h00, exp_ch(c, l, en_pin)});
    end
    $display("control loop done");
    r = rnd();
    cur0 = r[8:0];
    cur1 = r[17:9];
    for (int k = 0; k < 4; k++) begin
      host.wr_byte(ofs[k], 8'hFF);
      check_rd(ofs[k], fld[k]);
    end
    check({mask_a, mask_b}, {fld[0], fld[1]});
    check({reg_mask, 7'h00, load_select}, {fld[2], fld[3]});
    check_rd(8'h30, 8'h00);
    check_rd(8'h25, {7'h00, cur1[8]});
    check_rd(8'h26, cur1[7:0]);
    host.wr_byte(8'h24, 8'h00);
    check_rd(8'h25, {7'h00, cur0[8]});
    check_rd(8'h26, cur0[7:0]);
    $display("mask and load current done");
    stop_test();
  end
endmodule
